// [core/card_bus_defines.vh]
// Purpose: shared constants of the memory card bus interface
// Assumes: included by bare name by every core file
// Notes:   widths and codes only, no logic
`ifndef CARD_BUS_DEFINES_VH
`define CARD_BUS_DEFINES_VH

// serial byte framing
`define BYTE_BITS     8
`define BIT_CNT_W     3
`define BIT_CNT_ZERO  3'h0
`define BIT_CNT_ONE   3'h1
`define BIT_LAST      3'h7
`define IDLE_BYTE     8'hFF
`define MSB_POS       7

// native card mode data lines
`define DATA_LINES    4
`define NIBBLE_ZERO   4'h0
`define MMC_LINE_MASK 4'h1
`define SD_LINE_MASK  4'hF

// receive buffer
`define FIFO_DEPTH    8
`define FIFO_AW       3

// pin synchroniser bundle
`define PIN_SYNC_W    8
`define PIN_SYNC_ZERO 8'h00
`define PIN_LINK_CLK  7
`define PIN_CS_N      6
`define PIN_MOSI      5
`define PIN_CMD       4

`endif

// [core/pin_sync.v]
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: pins are levels from outside the clock domain
// Notes:   first stage is read only by the second stage
`default_nettype none
`include "card_bus_defines.vh"

module pin_sync #(
  parameter WIDTH = `PIN_SYNC_W
) (
  // clock and control
  input  wire             clock,
  input  wire             rst,
  input  wire             clkEn,
  // pin levels
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinOut
);

  reg [WIDTH-1:0] stage1;

  // two stage capture, frozen while clock enable is low
  always @(posedge clock) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b0}};
      pinOut <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end

endmodule // pin_sync
`default_nettype wire

// [core/byte_fifo.v]
// Purpose: small synchronous FIFO with valid and ready on both sides
// Assumes: single clock, depth is a power of two matching AW
// Notes:   full and empty come from an occupancy count
`default_nettype none
`include "card_bus_defines.vh"

module byte_fifo #(
  parameter WIDTH = `BYTE_BITS,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  // clock and control
  input  wire             clock,
  input  wire             rst,
  input  wire             clkEn,
  // fill side
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  // drain side
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      level;

  wire doWrite = inValid & inReady & clkEn;
  wire doRead  = outValid & outReady & clkEn;

  // honest full and empty
  assign inReady  = (level != DEPTH[AW:0]);
  assign outValid = (level != {(AW+1){1'b0}});
  assign outData  = store[rdPtr];

  // storage write
  always @(posedge clock) begin
    if (doWrite) begin
      store[wrPtr] <= inData;
    end
  end

  // pointers and occupancy
  always @(posedge clock) begin
    if (rst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doRead) begin
        rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doWrite & ~doRead) begin
        level <= level + {{AW{1'b0}}, 1'b1};
      end else if (doRead & ~doWrite) begin
        level <= level - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // byte_fifo
`default_nettype wire

// [core/memory_card_bus_interface.v]
// Purpose: card-side signal interface for SPI and native card mode
// Assumes: host makes the link clock; it is sampled here as a pin
// Notes:   received bytes pass an 8-word FIFO to the user side
`default_nettype none
`include "card_bus_defines.vh"

// Function
// - SPI: card selected while chip select low, deselected while high.
// - SPI transfer unit is one eight-bit byte, one bit per clock.
// - Transmitter changes data on falling edge; receiver samples on rising.
// - Most significant bit first, least significant last, both directions.
// - Data not inverted: one is high level, zero is low level.
// - Host sends on master-out line; card answers on master-in line.
// - Command line open-drain during initialization, push-pull afterwards.
// - Host sends commands on command line; card sends responses back.
// - Card mode moves one bit per clock on command and data lines.
// - Line3 pull-up on after power-up, off once initialization completes.
// - Host may sense SD card presence through the line3 pull-up.
// - Data lines push-pull; only one party drives a line at once.
// - Data lines 1 and 2 exist only on SD; MMC uses line0 only.
module memory_card_bus_interface (
  // clock, reset and enable
  input  wire       clock,
  input  wire       rst,
  input  wire       clkEn,
  // mode control from card logic
  input  wire       cardMode,
  input  wire       isSdCard,
  input  wire       initDone,
  input  wire       cardFrame,
  input  wire       cmdDrive,
  input  wire       dataDrive,
  // host link clock pin
  input  wire       linkClock,
  // SPI mode pins
  input  wire       chipSelectN,
  input  wire       mosi,
  output reg        miso,
  output wire       misoOeN,
  // command line pin
  input  wire       cmdIn,
  output reg        cmdOut,
  output wire       cmdOeN,
  // card detect and data line 3 pin
  input  wire       detectOrDataLine3In,
  output wire       detectOrDataLine3Out,
  output wire       detectOrDataLine3OeN,
  output reg        pullUpEnable,
  // data lines 0 to 2
  input  wire       dataLine0In,
  output wire       dataLine0Out,
  output wire       dataLine0OeN,
  input  wire       dataLine1In,
  output wire       dataLine1Out,
  output wire       dataLine1OeN,
  input  wire       dataLine2In,
  output wire       dataLine2Out,
  output wire       dataLine2OeN,
  // transmit byte source
  input  wire [7:0] txData,
  input  wire       txValid,
  output wire       txReady,
  // received byte sink
  output wire [7:0] rxData,
  output wire       rxValid,
  input  wire       rxReady,
  // parallel data line access
  input  wire [3:0] dataNibbleOut,
  output reg  [3:0] dataNibbleIn,
  output reg        dataStrobe,
  // status
  output reg        overrun,
  input  wire       overrunClear,
  output reg        frameActive
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // true on a low to high step between two samples
  function isRise;
    input cur;
    input prev;
    begin
      isRise = cur & ~prev;
    end
  endfunction

  // active data lines for the card type
  function [3:0] lineMask;
    input sd;
    begin
      lineMask = sd ? `SD_LINE_MASK : `MMC_LINE_MASK;
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisation and link clock edges
  // ---------------------------------------------------------------

  wire [`PIN_SYNC_W-1:0] pinRaw;
  wire [`PIN_SYNC_W-1:0] pinSync;
  wire [3:0]             dataSync;
  reg                    prevLinkClk;
  wire                   sLinkClk;
  wire                   sChipSelN;
  wire                   sMosi;
  wire                   sCmd;
  wire                   riseEdge;
  wire                   fallEdge;

  // chip select travels inverted so a cleared synchroniser reads deselected
  assign pinRaw = {linkClock, ~chipSelectN, mosi, cmdIn,
                   detectOrDataLine3In, dataLine2In, dataLine1In,
                   dataLine0In};

  // every pin passes two flip-flops first
  pin_sync #(
    .WIDTH (`PIN_SYNC_W)
  ) pinSyncInst (
    .clock  (clock),
    .rst    (rst),
    .clkEn  (clkEn),
    .pinIn  (pinRaw),
    .pinOut (pinSync)
  );

  assign sLinkClk  = pinSync[`PIN_LINK_CLK];
  assign sChipSelN = ~pinSync[`PIN_CS_N];
  assign sMosi     = pinSync[`PIN_MOSI];
  assign sCmd      = pinSync[`PIN_CMD];
  assign dataSync  = pinSync[`DATA_LINES-1:0];

  // previous link clock sample; edges only, so a stopped clock is idle
  always @(posedge clock) begin
    if (rst) begin
      prevLinkClk <= 1'b0;
    end else if (clkEn) begin
      prevLinkClk <= sLinkClk;
    end
  end

  assign riseEdge = isRise(sLinkClk, prevLinkClk);
  assign fallEdge = isRise(prevLinkClk, sLinkClk);

  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------

  wire frameOn;
  wire frameStart;
  wire serialIn;
  wire txActive;
  wire rxEnable;

  // selected by low chip select in SPI, by the frame input in card mode
  assign frameOn = cardMode ? cardFrame : ~sChipSelN;

  // sample line: master-out in SPI, command line in card mode
  assign serialIn = cardMode ? sCmd : sMosi;

  // card mode sends only while a response is driven
  assign txActive = cardMode ? cmdDrive : 1'b1;
  assign rxEnable = cardMode ? ~cmdDrive : 1'b1;

  // frame activity register for start detection
  always @(posedge clock) begin
    if (rst) begin
      frameActive <= 1'b0;
    end else if (clkEn) begin
      frameActive <= frameOn;
    end
  end

  assign frameStart = frameOn & ~frameActive;

  // ---------------------------------------------------------------
  // byte shift engine
  // ---------------------------------------------------------------

  reg [`BIT_CNT_W-1:0] bitCount;
  reg [7:0]            rxShift;
  reg [7:0]            txShift;
  reg                  needLoad;
  wire                 loadNow;
  wire [7:0]           loadByte;
  wire                 byteDone;
  wire [7:0]           nextRxByte;
  wire                 fifoInReady;
  wire                 fifoPush;

  // load at frame start or on the falling edge after a whole byte
  assign loadNow  = clkEn & ((frameStart) |
                    (fallEdge & frameOn & needLoad));
  assign txReady  = loadNow & txActive & txValid;
  assign loadByte = (txActive & txValid) ? txData : `IDLE_BYTE;

  // assembled byte with the newest bit as least significant
  assign nextRxByte = {rxShift[`MSB_POS-1:0], serialIn};
  assign byteDone   = riseEdge & frameOn & (bitCount == `BIT_LAST);
  assign fifoPush   = byteDone & rxEnable;

  // bit counter and receive shift on rising edges
  always @(posedge clock) begin
    if (rst) begin
      bitCount <= `BIT_CNT_ZERO;
      rxShift  <= `IDLE_BYTE;
      needLoad <= 1'b0;
    end else if (clkEn) begin
      if (~frameOn) begin
        bitCount <= `BIT_CNT_ZERO;
        needLoad <= 1'b0;
      end else if (riseEdge) begin
        rxShift  <= nextRxByte;
        bitCount <= bitCount + `BIT_CNT_ONE;
        needLoad <= byteDone;
      end else if (fallEdge) begin
        needLoad <= 1'b0;
      end
    end
  end

  // transmit shift loads at frame start, otherwise changes only on falling edges, MSB first
  always @(posedge clock) begin
    if (rst) begin
      txShift <= `IDLE_BYTE;
    end else if (clkEn) begin
      if (loadNow) begin
        txShift <= loadByte;
      end else if (fallEdge & frameOn) begin
        txShift <= {txShift[`MSB_POS-1:0], 1'b1};
      end
    end
  end

  // serial outputs from flip-flops, held for the whole period
  always @(posedge clock) begin
    if (rst) begin
      miso   <= 1'b1;
      cmdOut <= 1'b1;
    end else if (clkEn) begin
      miso   <= txShift[`MSB_POS];
      cmdOut <= txShift[`MSB_POS];
    end
  end

  // master-in released while deselected or in card mode
  assign misoOeN = ~(~cardMode & frameOn);

  // open-drain drives only zeros until initialization is done
  assign cmdOeN = ~(cardMode & cmdDrive &
                    (initDone | ~cmdOut));

  // ---------------------------------------------------------------
  // receive buffer and overrun
  // ---------------------------------------------------------------

  byte_fifo #(
    .WIDTH (`BYTE_BITS),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) rxFifoInst (
    .clock    (clock),
    .rst      (rst),
    .clkEn    (clkEn),
    .inData   (nextRxByte),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .outData  (rxData),
    .outValid (rxValid),
    .outReady (rxReady)
  );

  // host clock cannot be stalled: a byte meeting a full FIFO is lost
  // and flagged; a new loss wins over a clear in the same cycle
  always @(posedge clock) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (clkEn) begin
      if (fifoPush & ~fifoInReady) begin
        overrun <= 1'b1;
      end else if (overrunClear) begin
        overrun <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // native card mode data lines
  // ---------------------------------------------------------------

  reg  [3:0] dataShift;
  wire [3:0] activeLines;
  wire       dataOn;

  assign activeLines = lineMask(isSdCard);
  assign dataOn      = cardMode & dataDrive;

  // new nibble presented on each falling edge while driving
  always @(posedge clock) begin
    if (rst) begin
      dataShift <= `SD_LINE_MASK;
    end else if (clkEn) begin
      if (fallEdge & dataOn) begin
        dataShift <= dataNibbleOut & activeLines;
      end
    end
  end

  // nibble sampled on each rising edge while the host drives
  always @(posedge clock) begin
    if (rst) begin
      dataNibbleIn <= `NIBBLE_ZERO;
      dataStrobe   <= 1'b0;
    end else if (clkEn) begin
      dataStrobe <= riseEdge & cardMode & ~dataDrive;
      if (riseEdge & cardMode & ~dataDrive) begin
        dataNibbleIn <= dataSync & activeLines;
      end
    end
  end

  assign dataLine0Out         = dataShift[0];
  assign dataLine1Out         = dataShift[1];
  assign dataLine2Out         = dataShift[2];
  assign detectOrDataLine3Out = dataShift[3];

  // push-pull drive only while the card owns the data lines
  assign dataLine0OeN = ~dataOn;
  assign dataLine1OeN = ~(dataOn & activeLines[1]);
  assign dataLine2OeN = ~(dataOn & activeLines[2]);
  // line 3 stays an input for card detect until initialized
  assign detectOrDataLine3OeN = ~(dataOn & activeLines[3] &
                                  initDone);

  // pull-up on from reset, off once initialization completes
  always @(posedge clock) begin
    if (rst) begin
      pullUpEnable <= 1'b1;
    end else if (clkEn) begin
      pullUpEnable <= ~initDone;
    end
  end

endmodule // memory_card_bus_interface
`default_nettype wire

// [verif/card_bus_sva.sv]
// Purpose: port assertions for the card bus interface
// Assumes: clkEn held high; bound from the bench top
// Notes:   line enables are judged once their mode inputs settled
`default_nettype none
module card_bus_sva (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // mode inputs
  input wire logic       cardMode,
  input wire logic       isSdCard,
  input wire logic       initDone,
  input wire logic       cmdDrive,
  input wire logic       dataDrive,
  input wire logic       chipSelectN,
  // line outputs
  input wire logic       misoOeN,
  input wire logic       cmdOut,
  input wire logic       cmdOeN,
  input wire logic       detectOrDataLine3OeN,
  input wire logic       pullUpEnable,
  input wire logic       dataLine0OeN,
  input wire logic       dataLine1OeN,
  // byte streams
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic [7:0] rxData,
  input wire logic       rxValid,
  input wire logic       rxReady
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [4:0] prevMode;
  wire logic  settled;
  // mode inputs as seen one cycle ago
  always @(posedge clock) begin
    prevMode <= {cardMode, isSdCard, initDone, cmdDrive, dataDrive};
  end
  assign settled = (prevMode == {cardMode, isSdCard, initDone, cmdDrive,
                                 dataDrive});
  property p_pullUp;
    !$past(rst) |-> pullUpEnable == !$past(initDone);
  endproperty
  a_pullUp: assert property (p_pullUp)
    else $error("pull-up does not follow init state");
  property p_line3Oe;
    settled |-> detectOrDataLine3OeN ==
      !(cardMode && dataDrive && isSdCard && initDone);
  endproperty
  a_line3Oe: assert property (p_line3Oe)
    else $error("line3 enable wrong");
  property p_data0Oe;
    settled |-> dataLine0OeN == !(cardMode && dataDrive);
  endproperty
  a_data0Oe: assert property (p_data0Oe)
    else $error("line0 enable wrong");
  property p_data1Oe;
    settled |-> dataLine1OeN == !(cardMode && dataDrive && isSdCard);
  endproperty
  a_data1Oe: assert property (p_data1Oe)
    else $error("line1 enable wrong");
  property p_cmdOpen;
    !initDone && !cmdOeN |-> !cmdOut;
  endproperty
  a_cmdOpen: assert property (p_cmdOpen)
    else $error("cmd driven high before init");
  property p_cmdPush;
    settled && initDone && cardMode && cmdDrive |-> !cmdOeN;
  endproperty
  a_cmdPush: assert property (p_cmdPush)
    else $error("cmd not driven after init");
  property p_txTake;
    txReady |-> txValid;
  endproperty
  a_txTake: assert property (p_txTake)
    else $error("byte taken without valid");
  property p_rxHold;
    rxValid && !rxReady |=> rxValid && $stable(rxData);
  endproperty
  a_rxHold: assert property (p_rxHold)
    else $error("rx byte dropped while stalled");
  property p_idle;
    (!cardMode && chipSelectN) [*5] |-> misoOeN;
  endproperty
  a_idle: assert property (p_idle)
    else $error("miso driven while deselected");
endmodule // card_bus_sva
`default_nettype wire

// [verif/card_host_model.sv]
// Purpose: host controller model driving the card link
// Assumes: link clock of 160 ns, still and low between frames
// Notes:   reads the card's line at each rising link edge
`default_nettype none
module card_host_model (
  // link outputs
  output var logic linkClock,
  output var logic selectN,
  output var logic hostOut,
  // line from the card
  input wire logic cardIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // link driver
  // ---------------------------------------------------------------
  // idle bus: clock low, select and data high
  initial begin
    linkClock = 1'b0;
    selectN = 1'b1;
    hostOut = 1'b1;
  end
  // select, then give the card time to load its first bit
  task automatic select;
    #3 selectN = 1'b0;
    #200;
  endtask
  task automatic deselect;
    selectN = 1'b1;
    #200;
  endtask
  // data moves at the fall, the card line is read at the rise
  task automatic xfer(input logic [7:0] tx, input int nBits,
                      output logic [7:0] rx);
    int i;
    rx = 8'hFF;
    for (i = 7; i > 7 - nBits; i--) begin
      hostOut = tx[i];
      #80 linkClock = 1'b1;
      rx[i] = cardIn;
      #80 linkClock = 1'b0;
    end
    hostOut = 1'b1;
  endtask
endmodule // card_host_model
`default_nettype wire

// [verif/memory_card_bus_interface_test.sv]
// Purpose: self-checking bench for the card bus interface
// Assumes: clkEn held high; host model makes the link clock
// Notes:   inputs change at the falling edge of the system clock
`default_nettype none
module memory_card_bus_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // stimulus, lines and monitors
  // ---------------------------------------------------------------
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       clkEn = 1'b1;
  logic       cardMode = 1'b0;
  logic       isSdCard = 1'b1;
  logic       initDone = 1'b0;
  logic       cardFrame = 1'b0;
  logic       cmdDrive = 1'b0;
  logic       dataDrive = 1'b0;
  logic [7:0] txData = 8'hC1;
  logic       txValid = 1'b0;
  logic       rxReady = 1'b1;
  logic       overrunClear = 1'b0;
  logic [3:0] dataNibbleOut = 4'h0;
  logic [3:0] hostNib = 4'hA;
  logic [3:0] nibSeen = 4'h0;
  logic [7:0] rx;
  logic [7:0] rxq[$];
  int         nFail = 0;
  int         samplesChecked = 0;
  wire        linkClock, chipSelectN, hostOut, hostIn, mosi, miso, cmdIn;
  wire        misoOeN, cmdOut, cmdOeN, pullUpEnable, txReady, rxValid;
  wire        detectOrDataLine3In, detectOrDataLine3Out, detectOrDataLine3OeN;
  wire        dataLine0In, dataLine0Out, dataLine0OeN, dataLine1In;
  wire        dataLine1Out, dataLine1OeN, dataLine2In, dataLine2Out;
  wire        dataLine2OeN, dataStrobe, overrun, frameActive;
  wire [7:0]  rxData;
  wire [3:0]  dataNibbleIn;
  // wired levels: an enabled card driver wins, else host or pull-up
  assign mosi = hostOut;
  assign cmdIn = cmdOeN ? hostOut : cmdOut;
  assign hostIn = cardMode ? cmdIn : (misoOeN ? 1'b1 : miso);
  assign dataLine0In = dataLine0OeN ? hostNib[0] : dataLine0Out;
  assign dataLine1In = dataLine1OeN ? hostNib[1] : dataLine1Out;
  assign dataLine2In = dataLine2OeN ? hostNib[2] : dataLine2Out;
  assign detectOrDataLine3In = detectOrDataLine3OeN ? hostNib[3] :
                               detectOrDataLine3Out;
  always #10 clock = ~clock;
  // popped bytes and strobed nibbles
  always @(posedge clock) begin
    if (rxValid === 1'b1 && rxReady === 1'b1) rxq.push_back(rxData);
    if (dataStrobe === 1'b1) nibSeen <= dataNibbleIn;
  end
  memory_card_bus_interface dut_u (.*);
  card_host_model host_u (.linkClock(linkClock), .selectN(chipSelectN),
                          .hostOut(hostOut), .cardIn(hostIn));
  // ---------------------------------------------------------------
  // compare tasks and scenarios
  // ---------------------------------------------------------------
  task automatic checkByte(input string what, input logic [7:0] exp, got);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkBit(input string what, input logic exp, got);
    checkByte(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic expectRx(input logic [7:0] exp);
    checkByte("rx byte", exp, (rxq.size() > 0) ? rxq.pop_front() : 8'hXX);
  endtask
  task automatic tReset;
    checkBit("miso idle", 1'b1, miso);
    checkBit("miso enable", 1'b1, misoOeN);
    checkBit("cmd enable", 1'b1, cmdOeN);
    checkBit("pull-up", 1'b1, pullUpEnable);
    checkBit("line3 enable", 1'b1, detectOrDataLine3OeN);
    checkBit("rx valid", 1'b0, rxValid);
  endtask
  task automatic tSpi;
    @(negedge clock);
    txValid = 1'b1;
    host_u.select();
    checkBit("miso enable", 1'b0, misoOeN);
    checkBit("frame active", 1'b1, frameActive);
    host_u.xfer(8'h12, 8, rx);
    checkByte("miso byte", 8'hC1, rx);
    host_u.xfer(8'h80, 8, rx);
    checkByte("next miso byte", 8'hC1, rx);
    host_u.deselect();
    @(negedge clock);
    txValid = 1'b0;
    checkBit("miso released", 1'b1, misoOeN);
    checkBit("frame idle", 1'b0, frameActive);
    expectRx(8'h12);
    expectRx(8'h80);
  endtask
  task automatic tAbort;
    host_u.select();
    host_u.xfer(8'hF0, 4, rx);
    host_u.deselect();
    host_u.select();
    host_u.xfer(8'h5A, 8, rx);
    checkByte("idle byte", 8'hFF, rx);
    host_u.deselect();
    expectRx(8'h5A);
    checkByte("rx left", 8'h00, 8'(rxq.size()));
  endtask
  task automatic tOverrun;
    int i;
    @(negedge clock);
    rxReady = 1'b0;
    host_u.select();
    for (i = 0; i < 9; i++) host_u.xfer(8'h30 + 8'(i), 8, rx);
    host_u.deselect();
    checkBit("overrun", 1'b1, overrun);
    @(negedge clock);
    rxReady = 1'b1;
    repeat (12) @(negedge clock);
    for (i = 0; i < 8; i++) expectRx(8'h30 + 8'(i));
    checkByte("dropped byte", 8'h00, 8'(rxq.size()));
    overrunClear = 1'b1;
    @(negedge clock);
    overrunClear = 1'b0;
    @(negedge clock);
    checkBit("overrun cleared", 1'b0, overrun);
  endtask
  task automatic tCard;
    @(negedge clock);
    cardMode = 1'b1;
    cmdDrive = 1'b1;
    txValid = 1'b1;
    txData = 8'h2D;
    cardFrame = 1'b1;
    #203;
    host_u.xfer(8'hFF, 8, rx);
    checkByte("cmd response", 8'h2D, rx);
    checkBit("pull-up before init", 1'b1, pullUpEnable);
    @(negedge clock);
    cmdDrive = 1'b0;
    initDone = 1'b1;
    host_u.xfer(8'hA7, 8, rx);
    repeat (10) @(negedge clock);
    expectRx(8'hA7);
    checkBit("pull-up after init", 1'b0, pullUpEnable);
  endtask
  task automatic tData;
    cmdDrive = 1'b1;
    hostNib = 4'h9;
    host_u.xfer(8'hFF, 1, rx);
    repeat (10) @(negedge clock);
    checkByte("nibble in", 8'h09, {4'h0, nibSeen});
    dataDrive = 1'b1;
    isSdCard = 1'b0;
    dataNibbleOut = 4'hE;
    host_u.xfer(8'hFF, 1, rx);
    repeat (10) @(negedge clock);
    checkBit("line1 unused", 1'b1, dataLine1OeN);
    checkBit("line2 unused", 1'b1, dataLine2OeN);
    checkBit("line0 driven", 1'b0, dataLine0OeN);
    isSdCard = 1'b1;
    dataNibbleOut = 4'h6;
    host_u.xfer(8'hFF, 1, rx);
    repeat (10) @(negedge clock);
    checkByte("nibble out", 8'h06, {4'h0, detectOrDataLine3Out,
      dataLine2Out, dataLine1Out, dataLine0Out});
    checkBit("line3 driven", 1'b0, detectOrDataLine3OeN);
    cardFrame = 1'b0;
    dataDrive = 1'b0;
    cardMode = 1'b0;
  endtask
  // power cycle mid-run: reset again and expect the power-up state
  task automatic tRecover;
    @(negedge clock);
    initDone = 1'b0;
    rst = 1'b1;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (20) @(negedge clock);
    tReset();
  endtask
  task automatic tallyAndFinish;
    $display("checked %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(negedge clock);
    tReset();
    rst = 1'b0;
    repeat (20) @(negedge clock);
    tSpi();
    tAbort();
    tOverrun();
    tCard();
    tData();
    tRecover();
    tallyAndFinish();
  end
  // watchdog at about thirteen times the expected run
  initial begin
    #300000;
    nFail++;
    tallyAndFinish();
  end
endmodule // memory_card_bus_interface_test
bind memory_card_bus_interface card_bus_sva chk_u (.*);
`default_nettype wire
